// ==== verilog/rrs_pkg.sv ====
package rrs_pkg;
    localparam logic [6:0] RRS_DEV_ID = 7'h68;
    localparam int RRS_PTR_W = 5;
    localparam logic [4:0] RRS_PTR_RESET = 5'h00;
    localparam logic [4:0] RRS_PTR_LAST = 5'h1f;
    localparam logic [4:0] RRS_PTR_FIRST = 5'h00;
    localparam logic [3:0] RRS_BIT_LAST = 4'h7;
    localparam logic [3:0] RRS_BIT_ACK = 4'h8;
    localparam logic [3:0] RRS_BIT_FIRST = 4'h0;
    localparam logic [3:0] RRS_BIT_STEP = 4'h1;
    localparam logic [4:0] RRS_PTR_STEP = 5'h01;
    typedef enum logic [2:0] {
        RRS_IDLE = 3'b000,
        RRS_ADDR = 3'b001,
        RRS_REG = 3'b010,
        RRS_SEND = 3'b011,
        RRS_MACK = 3'b100,
        RRS_WAIT = 3'b101
    } rrs_state_t;
endpackage

// ==== verilog/rrs_byte_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface rrs_byte_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== verilog/rrs_skid_buf.sv ====
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer; a stall on the drain side never drops a byte
module rrs_skid_buf (
    input wire logic ref_clk,
    input wire logic rst,
    rrs_byte_if.dst in_if,
    rrs_byte_if.src out_if,
    input wire logic flush
);
    logic [7:0] mem [0:1];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    assign in_if.ready = (count != 2'h2);
    assign out_if.valid = (count != 2'h0);
    assign out_if.data = mem[rd_ptr];
    assign push = in_if.valid && in_if.ready;
    assign pop = out_if.valid && out_if.ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_if.data;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else if (flush) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    a_count_bound: assert property (@(posedge ref_clk) disable iff (rst)
        count <= 2'h2) else $error("buffer count above two");
endmodule
`default_nettype wire

// ==== verilog/rrs_read_seq.sv ====
// Summary of operation
// - the block acknowledges both address bytes and the register byte.
// - data bytes continue while the master acknowledges in the ninth clock.
// - the pointer loads from the register byte and selects each sent byte.
// - the pointer advances by one per byte transmitted.
// - the pointer wraps from 1Fh to 00h and data keeps flowing.
// - only an address whose upper seven bits are 1101000 is acknowledged.
// - the pointer is zero after reset so a current-address read starts at 0.
// - every byte is shifted most significant bit first.
`timescale 1ns/1ps
`default_nettype none
module rrs_read_seq (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [rrs_pkg::RRS_PTR_W-1:0] reg_addr,
    input wire logic [7:0] reg_data,
    output logic busy
);
    import rrs_pkg::*;

    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    rrs_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic [RRS_PTR_W-1:0] ptr;
    logic ack_phase;
    logic fetch;
    logic fetch_pend;
    logic byte_done;
    logic [7:0] next_byte;
    rrs_byte_if buf_in ();
    rrs_byte_if buf_out ();

    // pins come from another domain
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
        end
    end

    assign scl_rise = scl_sync[1] && !scl_d;
    assign scl_fall = !scl_sync[1] && scl_d;
    assign start_seen = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
    assign stop_seen = scl_sync[1] && scl_d && !sda_d && sda_sync[1];
    assign byte_done = scl_rise && (bit_cnt == RRS_BIT_LAST);
    assign next_byte = {shift_in[6:0], sda_sync[1]};

    // fetch path: array byte goes through the buffer to the shifter
    assign buf_in.valid = fetch_pend;
    assign buf_in.data = reg_data;
    assign buf_out.ready = fetch;

    rrs_skid_buf u_buf (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_if(buf_in),
        .out_if(buf_out),
        .flush(start_seen || stop_seen)
    );

    // pointer; reset value zero gives current-address reads from 0
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ptr <= RRS_PTR_RESET;
        end else if (state == RRS_REG && byte_done) begin
            ptr <= next_byte[RRS_PTR_W-1:0];
        end else if (fetch_pend && buf_in.ready) begin
            // wraps 1f -> 00 by width
            ptr <= ptr + RRS_PTR_STEP;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_addr <= RRS_PTR_RESET;
        end else begin
            reg_addr <= ptr;
        end
    end

    // one prefetch per data byte; the stall keeps it pending if full
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fetch_pend <= 1'b0;
        end else if (start_seen || stop_seen) begin
            fetch_pend <= 1'b0;
        end else if (state == RRS_ADDR && byte_done && next_byte[0]
                     && next_byte[7:1] == RRS_DEV_ID) begin
            fetch_pend <= 1'b1;
        end else if (state == RRS_MACK && scl_rise && !sda_sync[1]) begin
            fetch_pend <= 1'b1;
        end else if (buf_in.ready) begin
            fetch_pend <= 1'b0;
        end
    end

    // main sequencer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= RRS_IDLE;
            bit_cnt <= RRS_BIT_FIRST;
            shift_in <= 8'h00;
            ack_phase <= 1'b0;
        end else if (start_seen) begin
            state <= RRS_ADDR;
            bit_cnt <= RRS_BIT_FIRST;
            ack_phase <= 1'b0;
        end else if (stop_seen) begin
            state <= RRS_IDLE;
            ack_phase <= 1'b0;
        end else begin
            unique case (state)
                RRS_IDLE, RRS_WAIT: begin
                    ack_phase <= 1'b0;
                end
                RRS_ADDR, RRS_REG: begin
                    if (scl_rise && !ack_phase) begin
                        shift_in <= next_byte;
                        bit_cnt <= bit_cnt + RRS_BIT_STEP;
                    end
                    if (byte_done && !ack_phase) begin
                        if (next_byte[7:1] != RRS_DEV_ID
                            && state == RRS_ADDR) begin
                            state <= RRS_WAIT;
                        end else begin
                            ack_phase <= 1'b1;
                        end
                    end
                    if (ack_phase && scl_fall && bit_cnt == RRS_BIT_ACK) begin
                        bit_cnt <= RRS_BIT_FIRST;
                    end
                    if (ack_phase && scl_fall && bit_cnt == RRS_BIT_FIRST) begin
                        ack_phase <= 1'b0;
                        if (state == RRS_REG) begin
                            state <= RRS_WAIT;
                        end else if (shift_in[0]) begin
                            state <= RRS_SEND;
                        end else begin
                            state <= RRS_REG;
                        end
                    end
                end
                RRS_SEND: begin
                    // after a master ack the next msb opens at this fall
                    if (scl_fall && ack_phase) begin
                        ack_phase <= 1'b0;
                    end else if (scl_fall) begin
                        if (bit_cnt == RRS_BIT_LAST) begin
                            state <= RRS_MACK;
                            bit_cnt <= RRS_BIT_FIRST;
                        end else begin
                            bit_cnt <= bit_cnt + RRS_BIT_STEP;
                        end
                    end
                end
                RRS_MACK: begin
                    if (scl_rise) begin
                        state <= sda_sync[1] ? RRS_WAIT : RRS_SEND;
                        ack_phase <= !sda_sync[1];
                    end
                end
                default: begin
                    state <= RRS_IDLE;
                end
            endcase
        end
    end

    // ack_phase wraps bit_cnt: 8 at byte end, cleared to 0 on ack drive
    // load the next byte at the falling edge that opens its first bit
    assign fetch = buf_out.valid && scl_fall && (
        (state == RRS_ADDR && ack_phase && bit_cnt == RRS_BIT_FIRST
         && shift_in[0])
        || (state == RRS_SEND && ack_phase));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shift_out <= 8'hff;
        end else if (fetch) begin
            shift_out <= buf_out.data;
        end else if (state == RRS_SEND && scl_fall && !ack_phase) begin
            shift_out <= {shift_out[6:0], 1'b1};
        end
    end

    // sda drive: ack low in ninth clock of received bytes, else data zeros
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            busy <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            busy <= (state != RRS_IDLE) && (state != RRS_WAIT);
            if (start_seen || stop_seen) begin
                sda_oe <= 1'b0;
            end else if (scl_fall) begin
                if ((state == RRS_ADDR || state == RRS_REG) && ack_phase
                    && bit_cnt == RRS_BIT_ACK) begin
                    sda_oe <= 1'b1;
                end else if (state == RRS_SEND && ack_phase) begin
                    sda_oe <= !buf_out.data[7];
                end else if (state == RRS_SEND) begin
                    sda_oe <= (bit_cnt == RRS_BIT_LAST) ? 1'b0
                        : !shift_out[6];
                end else if (ack_phase && bit_cnt == RRS_BIT_FIRST
                             && state == RRS_ADDR && shift_in[0]) begin
                    sda_oe <= !buf_out.data[7];
                end else if (state == RRS_MACK) begin
                    sda_oe <= 1'b0;
                end else begin
                    sda_oe <= 1'b0;
                end
            end else if (state == RRS_MACK && scl_rise && !sda_sync[1]) begin
                sda_oe <= 1'b0;
            end else if (state == RRS_WAIT) begin
                sda_oe <= 1'b0;
            end
        end
    end

    a_reject_id: assert property (@(posedge ref_clk) disable iff (rst)
        (state == RRS_ADDR && byte_done && !ack_phase
         && next_byte[7:1] != RRS_DEV_ID) |=> state == RRS_WAIT)
        else $error("foreign address not rejected");
    a_nack_stop: assert property (@(posedge ref_clk) disable iff (rst)
        (state == RRS_MACK && scl_rise && sda_sync[1] && !start_seen
         && !stop_seen) |=> (state == RRS_WAIT) ##1 !sda_oe)
        else $error("bus not released after nack");
    a_ptr_step: assert property (@(posedge ref_clk) disable iff (rst)
        (fetch_pend && buf_in.ready && !(state == RRS_REG && byte_done))
        |=> ptr == $past(ptr) + RRS_PTR_STEP)
        else $error("pointer did not step by one");
    a_ptr_wrap: assert property (@(posedge ref_clk) disable iff (rst)
        (ptr == RRS_PTR_LAST && fetch_pend && buf_in.ready
         && !(state == RRS_REG && byte_done)) |=> ptr == RRS_PTR_FIRST)
        else $error("pointer failed to wrap");
    a_ptr_load: assert property (@(posedge ref_clk) disable iff (rst)
        (state == RRS_REG && byte_done && !ack_phase)
        |=> ptr == $past(next_byte[RRS_PTR_W-1:0]))
        else $error("pointer not loaded from register byte");
    a_ack_drive: assert property (@(posedge ref_clk) disable iff (rst)
        ((state == RRS_ADDR || state == RRS_REG) && ack_phase && scl_fall
         && bit_cnt == RRS_BIT_ACK && !start_seen && !stop_seen)
        |=> sda_oe && !sda_out) else $error("ack not driven");
    a_wait_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        (state == RRS_WAIT) ##1 (state == RRS_WAIT) |-> !sda_oe)
        else $error("bus driven while waiting");
    a_more_data: assert property (@(posedge ref_clk) disable iff (rst)
        (state == RRS_MACK && scl_rise && !sda_sync[1] && !start_seen
         && !stop_seen) |=> state == RRS_SEND && fetch_pend)
        else $error("ack did not continue the read");
endmodule
`default_nettype wire

// ==== dv/rrs_i2c_master.sv ====
`timescale 1ns/1ps
`default_nettype none
// bus master model: scl stands high between frames, a released sda
// reads back as the pull-up level; q sets a quarter bit, so raising it
// models a slow master
module rrs_i2c_master (
    input wire logic ref_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_pull,
    output logic rx_valid,
    output logic [7:0] rx_data
);
    int q = 6;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // also serves as repeated start when scl is low
    task automatic start_cond();
        sda_pull <= 1'b0;
        tick(q);
        scl <= 1'b1;
        tick(2 * q);
        sda_pull <= 1'b1;
        tick(2 * q);
        scl <= 1'b0;
        tick(q);
    endtask
    task automatic stop_cond();
        sda_pull <= 1'b1;
        tick(q);
        scl <= 1'b1;
        tick(2 * q);
        sda_pull <= 1'b0;
        tick(2 * q);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_pull <= ~b;
        tick(q);
        scl <= 1'b1;
        tick(q);
        r = sda;
        tick(q);
        scl <= 1'b0;
        tick(q);
    endtask
    task automatic byte_io(input logic [7:0] w, input logic nine,
                           output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
        bit_io(nine, a);
    endtask
    task automatic post(input logic [7:0] v);
        rx_data <= v;
        rx_valid <= 1'b1;
        tick(1);
        rx_valid <= 1'b0;
    endtask
    // byte from master; result is the slave's ninth bit
    task automatic send(input logic [7:0] w);
        logic [7:0] r;
        logic a;
        byte_io(w, 1'b1, r, a);
        post({7'h00, a});
    endtask
    // byte from slave; ack unless last
    task automatic fetch(input logic last);
        logic [7:0] r;
        logic a;
        byte_io(8'hff, last, r, a);
        post(r);
    endtask
endmodule
`default_nettype wire

// ==== dv/test_rtc_i2c_read_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_rtc_i2c_read_sequencer;
    logic ref_clk;
    logic rst;
    wire scl;
    wire sda_pull;
    wire sda;
    wire sda_out;
    wire sda_oe;
    wire busy;
    wire rx_valid;
    wire [4:0] reg_addr;
    wire [7:0] reg_data;
    wire [7:0] rx_data;
    logic [7:0] exp_v;
    logic [7:0] mem [0:31];
    logic [7:0] bad [4] = '{8'hd2, 8'h50, 8'hd9, 8'hf1};
    logic [7:0] exp_q [$];
    int mismatches = 0;
    int compares = 0;
    int seed = 32'h5762;
    // open-drain wire with pull-up
    assign sda = ~(sda_pull | (sda_oe & ~sda_out));
    assign reg_data = mem[reg_addr];
    rrs_read_seq dut (
        .ref_clk(ref_clk),
        .rst(rst),
        .scl_in(scl),
        .sda_in(sda),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .reg_addr(reg_addr),
        .reg_data(reg_data),
        .busy(busy)
    );
    rrs_i2c_master m (
        .ref_clk(ref_clk),
        .sda(sda),
        .scl(scl),
        .sda_pull(sda_pull),
        .rx_valid(rx_valid),
        .rx_data(rx_data)
    );
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] expv);
        compares++;
        if (seen !== expv) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, expv, seen);
        end
    endtask
    task automatic complete_run();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        if (rx_valid) begin
            exp_v = exp_q.size() ? exp_q.pop_front() : 8'hxx;
            check("rx_byte", rx_data, exp_v);
        end
    end
    // read n bytes from pointer p; the last one is not acknowledged
    task automatic stream(input logic [4:0] p, input int n);
        for (int k = 0; k < n; k++) begin
            exp_q.push_back(mem[p]);
            m.fetch(k == n - 1);
            p = p + 5'h01;
        end
    endtask
    task automatic random_read(input logic [7:0] ra, input int n);
        m.start_cond();
        exp_q.push_back(8'h00);
        m.send(8'hd0);
        exp_q.push_back(8'h00);
        m.send(ra);
        m.start_cond();
        exp_q.push_back(8'h00);
        m.send(8'hd1);
        stream(ra[4:0], n);
        m.stop_cond();
    endtask
    initial begin
        for (int i = 0; i < 32; i++) mem[i] = 8'($random(seed));
        rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        m.tick(5);
        // current-address read straight after reset starts at zero
        m.start_cond();
        exp_q.push_back(8'h00);
        m.send(8'hd1);
        check("busy", {7'h00, busy}, 8'h01);
        stream(5'h00, 3);
        m.stop_cond();
        // upper register bits ignored; pointer wraps past the top
        random_read(8'hfe, 5);
        // foreign addresses are refused
        foreach (bad[i]) begin
            m.start_cond();
            exp_q.push_back(8'h01);
            m.send(bad[i]);
            m.stop_cond();
        end
        // slow and fast masters with random pointers and lengths
        for (int t = 0; t < 6; t++) begin
            m.q = 6 + ($unsigned($random(seed)) % 5);
            random_read(8'($random(seed)), 1 + ($unsigned($random(seed)) % 4));
        end
        m.q = 6;
        // after a not-acknowledge the line must stay released
        random_read(8'h10, 1);
        m.start_cond();
        exp_q.push_back(8'h00);
        m.send(8'hd1);
        exp_q.push_back(mem[5'h11]);
        m.fetch(1'b1);
        exp_q.push_back(8'hff);
        m.fetch(1'b1);
        m.stop_cond();
        m.tick(10);
        check("busy_idle", {7'h00, busy}, 8'h00);
        check("pending", 8'(exp_q.size()), 8'h00);
        complete_run();
    end
    initial begin
        repeat (80000) @(posedge ref_clk);
        mismatches++;
        complete_run();
    end
endmodule
`default_nettype wire
